// [cgt_pkg.sv]
// Package with register map, field layout, reset values and types of the clock generation tree.
package cgt_pkg;

  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] CGT_LOOP_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CGT_FREQ_SEL_ADDR  = 8'h04;
  localparam logic [7:0] CGT_PORT_F_ADDR    = 8'h08;
  localparam logic [7:0] CGT_POWER_ADDR     = 8'h0C;
  localparam logic [7:0] CGT_STATUS_ADDR    = 8'h10;

  // Loop control register fields.
  localparam int CGT_SYS_SEL_LSB  = 8;
  localparam int CGT_PNL_SEL_LSB  = 11;
  localparam int CGT_FIRST_PRESCALE_SELECT_BIT   = 5;
  localparam int CGT_SECOND_PRESCALE_SELECT_BIT   = 6;
  localparam int CGT_CLKO_EN_BIT  = 4;
  localparam int CGT_LOOP_DIS_BIT = 3;

  // Frequency select register fields.
  localparam int CGT_Q_LSB = 8;
  localparam int CGT_P_LSB = 0;

  // Port F function select: bit 2 routes the shared pin to the port.
  localparam int CGT_PF_CLKO_BIT = 2;

  // Power register: sleep request and burst width.
  localparam int CGT_SLEEP_BIT   = 7;
  localparam int CGT_BURST_LSB   = 0;

  // Reset values.
  localparam logic [15:0] CGT_LOOP_CTRL_RST = 16'h24B3;
  localparam logic [15:0] CGT_FREQ_SEL_RST  = 16'h0347;
  localparam logic [7:0]  CGT_PORT_F_RST    = 8'h87;
  localparam logic [7:0]  CGT_POWER_RST     = 8'h1F;

  // Loop model: multiplier limits and the two crystal rates.
  localparam int          CGT_REF_HZ_A     = 32768;
  localparam int          CGT_REF_HZ_B     = 38400;
  localparam logic [3:0]  CGT_Q_MIN        = 4'h1;
  localparam logic [3:0]  CGT_Q_MAX        = 4'hE;
  localparam logic [15:0] CGT_Q_STEP       = 16'h000E;
  localparam logic [4:0]  CGT_BURST_FULL   = 5'h1F;

  // AHB-Lite transfer type codes.
  localparam logic [1:0] CGT_HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic        sel;
    logic [7:0]  addr;
    logic        write;
  } cgt_ahb_req_t;

  typedef struct packed {
    logic display_dma;
    logic system;
    logic panel;
    logic processor;
    logic first_presc;
  } cgt_clk_en_t;

endpackage : cgt_pkg

// [cgt_clock_tree.sv]
// Clock generation tree with AHB-Lite control registers.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module cgt_clock_tree
  import cgt_pkg::*;
#(
  parameter int MULT_W = 16
) (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               low_freq_ref_clock,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output cgt_pkg::cgt_clk_en_t    clk_en,
  output logic                    system_clock_out_pin,
  output logic                    system_clock_out_oe,
  output logic      [MULT_W-1:0]  loop_multiplier,
  output logic                    loop_setting_bad
);
  import cgt_pkg::*;

  logic [15:0]  loop_control_reg_q;
  logic [15:0]  loop_freq_select_reg_q;
  logic [7:0]   port_f_function_select_q;
  logic [7:0]   power_q;
  cgt_ahb_req_t req_q;
  logic [2:0]   ref_sync_q;
  logic         ref_level_q;
  logic         ref_seen_q;
  logic [2:0]   pnl_cnt_q;
  logic [2:0]   sys_cnt_q;
  logic         first_prescale_select_q;
  logic         second_prescale_select_q;
  logic [4:0]   burst_cnt_q;
  logic         sys_tgl_q;
  logic [31:0]  rd_word;

  // Multiplier of the loop for the modulus counts p and q.
  function automatic logic [MULT_W-1:0] loop_mult(input logic [7:0] p, input logic [3:0] q);
    logic [15:0] p_term;
    logic [15:0] m;
    p_term    = CGT_Q_STEP * ({8'h00, p} + 16'h0001);
    m         = 16'h0002 * (p_term + {12'h000, q} + 16'h0001);
    loop_mult = MULT_W'(m);
  endfunction : loop_mult

  // A pair of counts outside the range that the loop can lock to.
  function automatic logic setting_bad(input logic [7:0] p, input logic [3:0] q);
    logic q_out;
    logic p_low;
    q_out       = q < CGT_Q_MIN || q > CGT_Q_MAX;
    p_low       = {1'b0, p} < {5'h00, q} + 9'h001;
    setting_bad = q_out || p_low;
  endfunction : setting_bad

  // Last count of a divider: a set top select bit divides by eight, else by 2^sel[1:0].
  function automatic logic div_tick(input logic [2:0] cnt, input logic [2:0] sel);
    logic [2:0] last;
    if (sel[2]) begin
      last = 3'h7;
    end else begin
      last = 3'((4'h1 << sel[1:0]) - 4'h1);
    end
    div_tick = cnt == last;
  endfunction : div_tick

  // Data phase of a write to the register at addr.
  function automatic logic reg_hit(input cgt_ahb_req_t req, input logic [7:0] addr);
    reg_hit = req.sel && req.write && req.addr == addr;
  endfunction : reg_hit

  // Enable chain: a stage pulses only in a cycle in which the stage before it pulses.
  wire logic       bus_take = hsel && hready && htrans == CGT_HTRANS_NONSEQ;
  wire logic [7:0] p_cnt    = loop_freq_select_reg_q[CGT_P_LSB +: 8];
  wire logic [3:0] q_cnt    = loop_freq_select_reg_q[CGT_Q_LSB +: 4];
  wire logic       sleeping = power_q[CGT_SLEEP_BIT];
  wire logic       loop_run = !loop_control_reg_q[CGT_LOOP_DIS_BIT] && !sleeping;
  wire logic [2:0] sys_sel  = loop_control_reg_q[CGT_SYS_SEL_LSB +: 3];
  wire logic [2:0] pnl_sel  = loop_control_reg_q[CGT_PNL_SEL_LSB +: 3];
  wire logic       pr1_tick = loop_run && (first_prescale_select_q || !loop_control_reg_q[CGT_FIRST_PRESCALE_SELECT_BIT]);
  wire logic       dma_tick = pr1_tick && (second_prescale_select_q || !loop_control_reg_q[CGT_SECOND_PRESCALE_SELECT_BIT]);
  wire logic       sys_tick = dma_tick && div_tick(sys_cnt_q, sys_sel);
  wire logic       pnl_tick = dma_tick && div_tick(pnl_cnt_q, pnl_sel);
  wire logic [4:0] burst_w  = power_q[CGT_BURST_LSB +: 5];
  wire logic       proc_gate = burst_w == CGT_BURST_FULL || burst_cnt_q <= burst_w;

  // Address phase capture; the slave is always ready with an OKAY response.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= '0;
    end else if (hready) begin
      req_q <= '{sel: bus_take, addr: haddr[7:0], write: hwrite};
    end
  end

  // Each register takes its word in the data phase of a write to its address.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loop_control_reg_q <= CGT_LOOP_CTRL_RST;
    end else if (reg_hit(req_q, CGT_LOOP_CTRL_ADDR)) begin
      loop_control_reg_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loop_freq_select_reg_q <= CGT_FREQ_SEL_RST;
    end else if (reg_hit(req_q, CGT_FREQ_SEL_ADDR)) begin
      loop_freq_select_reg_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_f_function_select_q <= CGT_PORT_F_RST;
    end else if (reg_hit(req_q, CGT_PORT_F_ADDR)) begin
      port_f_function_select_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      power_q <= CGT_POWER_RST;
    end else if (reg_hit(req_q, CGT_POWER_ADDR)) begin
      power_q <= hwdata[7:0];
    end
  end

  // Read mux; the status word carries the multiplier, the reference flag and the range flag.
  always_comb begin
    case (haddr[7:0])
      CGT_LOOP_CTRL_ADDR: rd_word = {16'h0000, loop_control_reg_q};
      CGT_FREQ_SEL_ADDR:  rd_word = {16'h0000, loop_freq_select_reg_q};
      CGT_PORT_F_ADDR:    rd_word = {24'h000000, port_f_function_select_q};
      CGT_POWER_ADDR:     rd_word = {24'h000000, power_q};
      CGT_STATUS_ADDR:    rd_word = {14'h0000, loop_setting_bad, ref_seen_q, 16'(loop_multiplier)};
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // The slave never inserts wait states and always answers OKAY.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // The crystal reference runs in every mode and is only watched here. A level counts once
  // the second and third stages agree, so one slow edge is taken only once.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_sync_q <= 3'h0;
    end else begin
      ref_sync_q <= {ref_sync_q[1:0], low_freq_ref_clock};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_level_q <= 1'b0;
    end else if (ref_sync_q[1] == ref_sync_q[2]) begin
      ref_level_q <= ref_sync_q[2];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_seen_q <= 1'b0;
    end else if (ref_sync_q[1] == ref_sync_q[2] && ref_sync_q[2] != ref_level_q) begin
      ref_seen_q <= 1'b1;
    end
  end

  // Multiplier and its legal range follow the frequency select register.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loop_multiplier <= '0;
    end else begin
      loop_multiplier <= loop_mult(p_cnt, q_cnt);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loop_setting_bad <= 1'b0;
    end else begin
      loop_setting_bad <= setting_bad(p_cnt, q_cnt);
    end
  end

  // Prescalers divide by one or two in the loop clock domain, modelled as enables.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_prescale_select_q <= 1'b0;
    end else if (loop_run) begin
      first_prescale_select_q <= !first_prescale_select_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      second_prescale_select_q <= 1'b0;
    end else if (pr1_tick) begin
      second_prescale_select_q <= !second_prescale_select_q;
    end
  end

  // Output dividers of the display DMA clock; a new select is compared from the next DMA tick on, but a count past the new last runs on to a wrap first.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sys_cnt_q <= 3'h0;
    end else if (dma_tick) begin
      sys_cnt_q <= div_tick(sys_cnt_q, sys_sel) ? 3'h0 : sys_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pnl_cnt_q <= 3'h0;
    end else if (dma_tick) begin
      pnl_cnt_q <= div_tick(pnl_cnt_q, pnl_sel) ? 3'h0 : pnl_cnt_q + 3'h1;
    end
  end

  // Processor gets a burst of the system clock out of every 32 system ticks.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      burst_cnt_q <= 5'h00;
    end else if (sys_tick) begin
      burst_cnt_q <= burst_cnt_q + 5'h01;
    end
  end

  // One registered enable per generated clock; all of them idle while the loop is stopped.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_en <= '0;
    end else begin
      clk_en.first_presc <= pr1_tick;
      clk_en.display_dma <= dma_tick;
      clk_en.system      <= sys_tick;
      clk_en.panel       <= pnl_tick;
      clk_en.processor   <= sys_tick && proc_gate;
    end
  end

  // The pin shows a square wave toggling on each system tick.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sys_tgl_q <= 1'b0;
    end else if (sys_tick) begin
      sys_tgl_q <= !sys_tgl_q;
    end
  end

  // The pin copies the toggle one cycle later so that it comes straight from a flip-flop.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      system_clock_out_pin <= 1'b0;
      system_clock_out_oe  <= 1'b0;
    end else begin
      system_clock_out_pin <= sys_tgl_q;
      system_clock_out_oe  <= loop_control_reg_q[CGT_CLKO_EN_BIT] &&
                              !port_f_function_select_q[CGT_PF_CLKO_BIT];
    end
  end

endmodule : cgt_clock_tree

// [cgt_monitor.sv]
// Checker of the port relations of the clock generation tree.
`timescale 1ns/10ps
module cgt_monitor
  import cgt_pkg::*;
#(
  parameter int MULT_W = 16
) (
  input wire logic                 ref_clk,
  input wire logic                 nrst,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire cgt_pkg::cgt_clk_en_t clk_en,
  input wire logic [MULT_W-1:0]    loop_multiplier,
  input wire logic                 loop_setting_bad
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_release;
    $rose(nrst);
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_ready_up: assert property ($past(nrst) |-> hreadyout)
    else $error("hreadyout low after reset");
  a_mult_even: assert property (loop_multiplier[0] == 1'b0)
    else $error("odd multiplier");
  a_mult_floor: assert property ($past(nrst, 2) && !loop_setting_bad |-> loop_multiplier >= 88)
    else $error("multiplier below legal floor");
  a_dma_source: assert property (clk_en.display_dma |-> clk_en.first_presc)
    else $error("dma tick without prescaler tick");
  a_sys_source: assert property (clk_en.system |-> clk_en.display_dma)
    else $error("system tick without dma tick");
  a_panel_source: assert property (clk_en.panel |-> clk_en.display_dma)
    else $error("panel tick without dma tick");
  a_proc_source: assert property (clk_en.processor |-> clk_en.system)
    else $error("processor tick without system tick");
  a_dma_start: assert property (s_release |-> ##[1:8] clk_en.display_dma)
    else $error("no dma tick after reset");
endmodule : cgt_monitor

bind cgt_clock_tree cgt_monitor #(.MULT_W(MULT_W)) cgt_monitor_i (
  .ref_clk(ref_clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp), .clk_en(clk_en),
  .loop_multiplier(loop_multiplier), .loop_setting_bad(loop_setting_bad));

// [cgt_consumer_model.sv]
// Model of the crystal reference and of a consumer of the display DMA clock.
`timescale 1ns/10ps
module cgt_consumer_model
  import cgt_pkg::*;
#(
  parameter int REF_HALF = 16
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire cgt_pkg::cgt_clk_en_t clk_en,
  output logic                      low_freq_ref_clock = 1'b0,
  output logic [15:0]               dma_cnt_q
);
  logic [7:0] ref_div_q = 8'h00;
  // The crystal runs regardless of reset or sleep while power is on.
  always_ff @(posedge ref_clk) begin
    if (ref_div_q == 8'(REF_HALF - 1)) begin
      ref_div_q          <= 8'h00;
      low_freq_ref_clock <= ~low_freq_ref_clock;
    end else begin
      ref_div_q <= ref_div_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) dma_cnt_q <= 16'h0000;
    else if (clk_en.display_dma) dma_cnt_q <= dma_cnt_q + 16'h0001;
  end
endmodule : cgt_consumer_model

// [testbench.sv]
// Self-checking testbench of the clock generation tree.
`timescale 1ns/10ps
module testbench;
  import cgt_pkg::*;
  logic ref_clk, nrst, hsel, hwrite, hrd_y, hresp, pin, oe, bad, lfr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] mult, dcnt;
  cgt_pkg::cgt_clk_en_t clk_en;
  int n_fail = 0;
  int checked = 0;
  cgt_clock_tree cgt_clock_tree_i (.ref_clk(ref_clk), .nrst(nrst), .low_freq_ref_clock(lfr),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrd_y), .hrdata(hrdata), .hreadyout(hrd_y), .hresp(hresp),
    .clk_en(clk_en), .system_clock_out_pin(pin), .system_clock_out_oe(oe),
    .loop_multiplier(mult), .loop_setting_bad(bad));
  cgt_consumer_model cgt_consumer_model_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .low_freq_ref_clock(lfr), .dma_cnt_q(dcnt));
  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hrd_y !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1; htrans <= CGT_HTRANS_NONSEQ; haddr <= {24'h000000, a}; hwrite <= w;
    wait_ready();
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus
  function automatic logic [31:0] mul(input int p, input int q);
    return 32'(2 * (14 * (p + 1) + q + 1));
  endfunction : mul
  task automatic t_reset_values;
    bus(1'b0, CGT_LOOP_CTRL_ADDR, 32'h0); chk(rd, 32'(CGT_LOOP_CTRL_RST));
    bus(1'b0, CGT_FREQ_SEL_ADDR, 32'h0);  chk(rd, 32'(CGT_FREQ_SEL_RST));
    bus(1'b0, CGT_PORT_F_ADDR, 32'h0);    chk(rd, 32'(CGT_PORT_F_RST));
    bus(1'b0, CGT_POWER_ADDR, 32'h0);     chk(rd, 32'(CGT_POWER_RST));
    bus(1'b0, 8'h14, 32'h0);              chk(rd, 32'h0);
    chk(32'(mult), mul(71, 3));
  endtask : t_reset_values
  task automatic t_multiplier;
    logic [15:0] fs [3] = '{16'h041B, 16'h001B, 16'h0404};
    logic [31:0] m;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, CGT_FREQ_SEL_ADDR, 32'(fs[i]));
      bus(1'b0, CGT_STATUS_ADDR, 32'h0);
      m = mul(int'(fs[i][7:0]), int'(fs[i][11:8]));
      chk(rd & 32'h0002FFFF, {14'h0, i != 0, 1'b0, m[15:0]});
      chk(32'(rd[16]), 32'h0000_0001);
      chk(32'(bad), 32'(i != 0));
    end
    bus(1'b1, CGT_FREQ_SEL_ADDR, 32'(CGT_FREQ_SEL_RST));
  endtask : t_multiplier
  task automatic t_out_enable;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CGT_LOOP_CTRL_ADDR, i[0] ? 32'h24B3 : 32'h24A3);
      bus(1'b1, CGT_PORT_F_ADDR, i[1] ? 32'h87 : 32'h83);
      repeat (2) @(posedge ref_clk);
      chk(32'(oe), 32'(i == 1));
    end
  endtask : t_out_enable
  task automatic dma_window(input logic [7:0] a, input logic [31:0] v, input int exp);
    logic [15:0] c0;
    bus(1'b1, a, v);
    repeat (4) @(posedge ref_clk);
    c0 = dcnt;
    repeat (20) @(posedge ref_clk);
    chk(32'(dcnt - c0), 32'(exp));
  endtask : dma_window
  task automatic t_dividers;
    dma_window(CGT_LOOP_CTRL_ADDR, 32'h24B3, 10);
    dma_window(CGT_LOOP_CTRL_ADDR, 32'h24F3, 5);
    dma_window(CGT_LOOP_CTRL_ADDR, 32'h24B3, 10);
    dma_window(CGT_POWER_ADDR, 32'h9F, 0);
    dma_window(CGT_POWER_ADDR, 32'h1F, 10);
  endtask : t_dividers
  task automatic t_rates(input logic [31:0] lc, input int n_sys, input int n_pnl);
    int ns = 0;
    int np = 0;
    int nc = 0;
    int nt = 0;
    logic last;
    bus(1'b1, CGT_LOOP_CTRL_ADDR, lc);
    repeat (20) @(posedge ref_clk);
    last = pin;
    repeat (32) begin
      @(posedge ref_clk);
      ns += int'(clk_en.system);
      np += int'(clk_en.panel);
      nc += int'(clk_en.processor);
      nt += int'(pin != last);
      last = pin;
    end
    chk(32'(ns), 32'(n_sys));
    chk(32'(np), 32'(n_pnl));
    chk(32'(nc), 32'(n_sys));
    chk(32'(nt), 32'(n_sys));
  endtask : t_rates
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    nrst = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; haddr = 32'h0; hwdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_multiplier();
    t_out_enable();
    t_rates(32'h24B3, 2, 2);
    t_rates(32'h20B3, 16, 2);
    t_dividers();
    report_and_stop();
  end
endmodule : testbench
